// >>> shared/ssf_pkg.sv
package ssf_pkg;
    // Clock and timing figures
    localparam int CLK_HZ       = 25000000;
    localparam int BAUD_DEF     = 9600;
    localparam int CHAR_BITS    = 11;
    localparam int SILENT_X10   = 35;
    localparam int MS_UNIT_HZ   = 1000;
    localparam int TICK_UNIT_HZ = 100;
    localparam int SILENT_CYC   = ((CLK_HZ / BAUD_DEF) * CHAR_BITS * SILENT_X10 + 9) / 10;
    localparam int MS_CYC       = CLK_HZ / MS_UNIT_HZ;
    localparam int TICK_CYC     = CLK_HZ / TICK_UNIT_HZ;
    // Setting limits
    localparam logic [13:0] LIMIT_MAX = 14'd9999;
    localparam logic [10:0] DELAY_MAX = 11'd1000;
    // Control characters
    localparam logic [7:0] CH_STX   = 8'h02;
    localparam logic [7:0] CH_CR    = 8'h0d;
    localparam logic [7:0] CH_ACK   = 8'h06;
    localparam logic [7:0] CH_NAK   = 8'h15;
    localparam logic [7:0] CH_ZERO  = 8'h30;
    localparam logic [7:0] CH_ALPHA = 8'h37;
    localparam logic [7:0] ST_BCAST = 8'hff;
    localparam logic [7:0] ST_MAX   = 8'h20;
    localparam logic [7:0] ADDR_BC  = 8'h00;
    localparam logic [7:0] CMD_RECALC_HI = 8'h30;
    localparam logic [7:0] CMD_RECALC_LO = 8'h42;
    // Frame layout
    localparam logic [3:0] POS_CODE = 4'h3;
    localparam logic [3:0] LEN_POS  = 4'h7;
    localparam logic [3:0] LEN_NEG  = 4'h9;
    // CRC
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'ha001;
    // Error codes; zero means positive answer
    typedef enum logic [7:0] {
        ERR_NONE     = 8'h00, ERR_PARITY = 8'h01, ERR_SUM   = 8'h02,
        ERR_FRAMING  = 8'h03, ERR_OVERRUN = 8'h04, ERR_PROTO = 8'h05,
        ERR_CHAR     = 8'h06, ERR_BUF_OVF = 8'h07, ERR_RX_TO = 8'h08,
        ERR_COMMAND  = 8'h11, ERR_EXEC_DIS = 8'h13, ERR_PARAM = 8'h16
    } ssf_err_type;
    // Reaction to a reception timeout
    typedef enum logic [2:0] {
        REACT_TRIP = 3'b000, REACT_STOP_TRIP = 3'b001, REACT_IGNORE = 3'b010,
        REACT_COAST = 3'b011, REACT_DECEL = 3'b100
    } ssf_react_type;
    // Request for a character-mode answer
    typedef struct packed {
        logic [7:0]  station;
        ssf_err_type err;
    } ssf_char_req_type;
    // One transmit byte
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } ssf_tx_type;
endpackage

// >>> verilog/ssf_frame_mem.sv
`timescale 1ns/10ps
`default_nettype none
module ssf_frame_mem #(
    parameter int W = 8,
    parameter int D = 16
) (
    input  wire logic                 i_sys_clk,   // Clock
    input  wire logic                 i_wr_en,     // Write strobe
    input  wire logic [$clog2(D)-1:0] i_wr_addr,   // Write address
    input  wire logic [W-1:0]         i_wr_data,   // Write data
    input  wire logic [$clog2(D)-1:0] i_rd_addr,   // Read address
    output logic      [W-1:0]         o_rd_data    // Registered read data
);
    logic [W-1:0] mem [D];

    // Write port
    always_ff @(posedge i_sys_clk) begin
        if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
    end

    // Registered read port
    always_ff @(posedge i_sys_clk) begin
        o_rd_data <= mem[i_rd_addr];
    end
endmodule // ssf_frame_mem
`default_nettype wire

// >>> verilog/ssf_framer.sv
`timescale 1ns/10ps
`default_nettype none
module ssf_framer
    import ssf_pkg::*;
#(
    parameter int SILENT_CYCLES = SILENT_CYC,
    parameter int MS_CYCLES     = MS_CYC,
    parameter int TICK_CYCLES   = TICK_CYC
) (
    input  wire logic             i_sys_clk,          // Clock
    input  wire logic             i_reset_n,          // Synchronous reset
    input  wire logic [7:0]       i_station_id,       // Own number 1..32
    input  wire logic             i_char_req,         // Answer request pulse
    input  wire ssf_char_req_type i_char_info,        // Station and error
    input  wire logic             i_tx_ready,         // Transmitter takes byte
    output ssf_tx_type            o_tx,               // Byte to transmit
    output logic                  o_char_busy,        // Answer in progress
    input  wire logic             i_comm_enable,      // Binary mode active
    input  wire logic             i_bin_byte,         // Binary byte received
    input  wire logic [7:0]       i_bin_data,         // Binary byte value
    input  wire logic             i_bin_frame_start,  // First byte of query
    input  wire logic             i_bin_frame_end,    // Gap ended the query
    input  wire logic [13:0]      i_limit_time,       // Limit, 10 ms units
    input  wire logic [10:0]      i_extra_delay,      // Extra delay, ms
    input  wire ssf_react_type    i_timeout_react,    // Timeout reaction
    input  wire logic             i_motor_stopped,    // Motor at standstill
    output logic                  o_bin_exec,         // Execute query pulse
    output logic                  o_bin_resp_go,      // Send reply pulse
    output logic                  o_rx_restart,       // Discard query pulse
    output logic                  o_link_timeout_trip,// Trip level
    output logic                  o_decel_stop,       // Decelerate request
    output logic                  o_coast_to_stop     // Coast request
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, ST_FILL = 3'b001, ST_READ = 3'b010,
        ST_WAIT = 3'b011, ST_HOLD = 3'b100
    } ssf_state_type;

    ssf_state_type state;
    logic [3:0]    idx;
    logic [3:0]    frame_len;
    logic [3:0]    o_tx_pos;
    logic [7:0]    req_station;
    logic [7:0]    req_err;
    logic [7:0]    mem_rdata;
    logic [7:0]    fill_byte;
    logic [7:0]    bcc;
    logic          char_take;

    // Hex character of one nibble, uppercase
    function automatic logic [7:0] hex_char(input logic [3:0] n);
        hex_char = (n > 4'h9) ? CH_ALPHA + {4'h0, n} : CH_ZERO + {4'h0, n};
    endfunction

    // Decimal tens and units characters of a station number
    function automatic logic [7:0] dec_tens(input logic [7:0] s);
        dec_tens = (s >= 8'h1e) ? 8'h33 : (s >= 8'h14) ? 8'h32 : (s >= 8'h0a) ? 8'h31 : CH_ZERO;
    endfunction
    function automatic logic [7:0] dec_units(input logic [7:0] s);
        dec_units = CH_ZERO + s - ((dec_tens(s) - CH_ZERO) * 8'h0a);
    endfunction

    // station range; own number only, broadcast handled apart
    assign char_take = i_char_req && (state == ST_IDLE)
                       && (i_char_info.station == i_station_id)
                       && (i_station_id != 8'h00) && (i_station_id <= ST_MAX);

    // XOR check; through ACK, through error code
    always_comb begin
        bcc = dec_tens(req_station) ^ dec_units(req_station);
        if (req_err == ERR_NONE) begin
            bcc = bcc ^ CH_ACK;
        end else begin
            bcc = bcc ^ CH_NAK ^ hex_char(req_err[7:4]) ^ hex_char(req_err[3:0]);
        end
    end

    always_comb begin
        fill_byte = CH_CR;
        case (idx)
            4'h0: fill_byte = CH_STX;
            4'h1: fill_byte = dec_tens(req_station);
            4'h2: fill_byte = dec_units(req_station);
            4'h3: fill_byte = (req_err == ERR_NONE) ? CH_ACK : CH_NAK;
            // check as hex text, high nibble first
            4'h4: fill_byte = (req_err == ERR_NONE) ? hex_char(bcc[7:4]) : hex_char(req_err[7:4]);
            4'h5: fill_byte = (req_err == ERR_NONE) ? hex_char(bcc[3:0]) : hex_char(req_err[3:0]);
            4'h6: fill_byte = (req_err == ERR_NONE) ? CH_CR : hex_char(bcc[7:4]);
            4'h7: fill_byte = hex_char(bcc[3:0]);
            default: fill_byte = CH_CR;
        endcase
    end

    ssf_frame_mem #(
        .W (8),
        .D (16)
    ) u_mem (
        .i_sys_clk (i_sys_clk),
        .i_wr_en   (state == ST_FILL),
        .i_wr_addr (idx),
        .i_wr_data (fill_byte),
        .i_rd_addr (idx),
        .o_rd_data (mem_rdata)
    );

    // Character answer sequencer
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            state       <= ST_IDLE;
            idx         <= 4'h0;
            frame_len   <= 4'h0;
            req_station <= 8'h00;
            req_err     <= 8'h00;
            o_tx        <= '0;
            o_tx_pos    <= 4'h0;
            o_char_busy <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    // broadcast never answered; answers only on request
                    if (char_take) begin
                        req_station <= i_char_info.station;
                        req_err     <= i_char_info.err;
                        frame_len   <= (i_char_info.err == ERR_NONE) ? LEN_POS : LEN_NEG;
                        idx         <= 4'h0;
                        o_char_busy <= 1'b1;
                        state       <= ST_FILL;
                    end
                end
                ST_FILL: begin
                    if (idx == frame_len - 4'h1) begin
                        idx   <= 4'h0;
                        state <= ST_READ;
                    end else begin
                        idx <= idx + 4'h1;
                    end
                end
                ST_READ: begin
                    state <= ST_WAIT;
                end
                ST_WAIT: begin
                    o_tx.valid <= 1'b1;
                    o_tx.data  <= mem_rdata;
                    o_tx_pos   <= idx;
                    state      <= ST_HOLD;
                end
                ST_HOLD: begin
                    if (i_tx_ready) begin
                        o_tx.valid <= 1'b0;
                        if (idx == frame_len - 4'h1) begin
                            o_char_busy <= 1'b0;
                            state       <= ST_IDLE;
                        end else begin
                            idx   <= idx + 4'h1;
                            state <= ST_READ;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Binary mode: CRC, address, supervision and reply timing
    logic [15:0] crc;
    logic [15:0] next_crc;
    logic [7:0]  bin_addr;
    logic        armed;
    logic        supervising;
    logic [31:0] tick_div;
    logic [13:0] tick_cnt;
    logic        timeout;
    logic        query_ok;
    logic        delaying;
    logic        in_silent;
    logic [31:0] delay_cnt;
    logic [10:0] ms_left;
    logic        react_wait;

    // reflected CRC-16 step over one byte, fresh seed on a query's first byte
    always_comb begin
        next_crc = (i_bin_frame_start ? CRC_INIT : crc) ^ {8'h00, i_bin_data};
        for (int b = 0; b < 8; b++) begin
            next_crc = next_crc[0] ? ((next_crc >> 1) ^ CRC_POLY) : (next_crc >> 1);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            crc      <= CRC_INIT;
            bin_addr <= 8'h00;
        end else if (i_bin_byte) begin
            crc      <= next_crc;
            bin_addr <= i_bin_frame_start ? i_bin_data : bin_addr;
        end
    end

    // residue zero; own address or broadcast
    assign query_ok = i_bin_frame_end && i_comm_enable && (crc == 16'h0000)
                      && ((bin_addr == i_station_id) || (bin_addr == ADDR_BC));

    // armed by first byte after reset; only in binary mode
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            armed <= 1'b0;
        end else if (i_bin_byte && i_comm_enable) begin
            armed <= 1'b1;
        end
    end

    // limit counted in 10 ms ticks, clamped to 99.99 s
    assign timeout = supervising && (i_limit_time != 14'd0)
                     && (tick_cnt >= ((i_limit_time > LIMIT_MAX) ? LIMIT_MAX : i_limit_time));

    // supervision window runs from arming, a reply or a broadcast query until an accepted query completes
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            supervising  <= 1'b0;
            tick_div     <= 32'd0;
            tick_cnt     <= 14'd0;
            o_rx_restart <= 1'b0;
        end else begin
            o_rx_restart <= 1'b0;
            if (!armed || !i_comm_enable || query_ok) begin
                supervising <= 1'b0;
                tick_div    <= 32'd0;
                tick_cnt    <= 14'd0;
            end else if (o_bin_resp_go || (armed && !supervising && !delaying)) begin
                supervising <= 1'b1;
                tick_div    <= 32'd0;
                tick_cnt    <= 14'd0;
            end else if (timeout) begin
                o_rx_restart <= 1'b1;
                tick_div     <= 32'd0;
                tick_cnt     <= 14'd0;
            end else if (tick_div == TICK_CYCLES - 1) begin
                tick_div <= 32'd0;
                tick_cnt <= tick_cnt + 14'd1;
            end else begin
                tick_div <= tick_div + 32'd1;
            end
        end
    end

    // silent gap, then extra delay, then reply
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            delaying      <= 1'b0;
            in_silent     <= 1'b0;
            delay_cnt     <= 32'd0;
            ms_left       <= 11'd0;
            o_bin_exec    <= 1'b0;
            o_bin_resp_go <= 1'b0;
        end else begin
            o_bin_exec    <= 1'b0;
            o_bin_resp_go <= 1'b0;
            if (query_ok && !delaying) begin
                o_bin_exec <= 1'b1;
                delaying   <= (bin_addr != ADDR_BC);
                in_silent  <= 1'b1;
                delay_cnt  <= 32'd0;
                ms_left    <= (i_extra_delay > DELAY_MAX) ? DELAY_MAX : i_extra_delay;
            end else if (delaying) begin
                if (in_silent) begin
                    if (delay_cnt == SILENT_CYCLES - 1) begin
                        in_silent <= 1'b0;
                        delay_cnt <= 32'd0;
                    end else begin
                        delay_cnt <= delay_cnt + 32'd1;
                    end
                end else if (ms_left == 11'd0) begin
                    // reply only after an accepted query
                    o_bin_resp_go <= 1'b1;
                    delaying      <= 1'b0;
                end else if (delay_cnt == MS_CYCLES - 1) begin
                    delay_cnt <= 32'd0;
                    ms_left   <= ms_left - 11'd1;
                end else begin
                    delay_cnt <= delay_cnt + 32'd1;
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            o_link_timeout_trip <= 1'b0;
            o_decel_stop        <= 1'b0;
            o_coast_to_stop     <= 1'b0;
            react_wait          <= 1'b0;
        end else begin
            if (o_rx_restart) begin
                case (i_timeout_react)
                    REACT_TRIP:      o_link_timeout_trip <= 1'b1;
                    REACT_STOP_TRIP: begin
                        o_decel_stop <= 1'b1;
                        react_wait   <= 1'b1;
                    end
                    REACT_COAST:     o_coast_to_stop <= 1'b1;
                    REACT_DECEL:     o_decel_stop <= 1'b1;
                    default:         react_wait <= react_wait;
                endcase
            end
            // trip once the motor has stopped
            if (react_wait && i_motor_stopped) begin
                o_link_timeout_trip <= 1'b1;
                react_wait          <= 1'b0;
            end
        end
    end

    // Checks
    sequence s_timeout_evt;
        o_rx_restart && (i_timeout_react == REACT_TRIP);
    endsequence
    sequence s_trip_seen;
        ##1 o_link_timeout_trip;
    endsequence

    stx_first_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        o_tx.valid && (o_tx_pos == 4'h0) |-> o_tx.data == CH_STX)
        else $error("frame does not open with start byte");
    cr_last_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        o_tx.valid && (o_tx_pos == frame_len - 4'h1) |-> o_tx.data == CH_CR)
        else $error("frame does not end with carriage return");
    ack_code_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        o_tx.valid && (o_tx_pos == POS_CODE) && (req_err == ERR_NONE) |-> o_tx.data == CH_ACK)
        else $error("positive answer lacks acknowledge");
    nak_code_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        o_tx.valid && (o_tx_pos == POS_CODE) && (req_err != ERR_NONE) |-> o_tx.data == CH_NAK)
        else $error("negative answer lacks negative acknowledge");
    bcast_quiet_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        i_char_req && (i_char_info.station == ST_BCAST) && !o_char_busy |=> !o_char_busy [*2])
        else $error("broadcast request started an answer");
    reply_gap_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        query_ok && !delaying |=> !o_bin_resp_go [*8])
        else $error("reply sent inside silent gap");
    trip_now_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        s_timeout_evt |-> s_trip_seen)
        else $error("timeout did not trip");
    ignore_to_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        o_rx_restart && (i_timeout_react == REACT_IGNORE) && !o_link_timeout_trip
        && !react_wait |=> !o_link_timeout_trip)
        else $error("ignored timeout raised a trip");
    coast_to_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        o_rx_restart && (i_timeout_react == REACT_COAST) |=> o_coast_to_stop)
        else $error("coast setting did not coast");
    disarmed_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        !armed |=> !o_rx_restart)
        else $error("timeout before first communication");
endmodule // ssf_framer
`default_nettype wire

// >>> bench/ssf_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module ssf_host_model
    import ssf_pkg::*;
(
    input  wire logic       i_sys_clk, // Clock
    input  wire ssf_tx_type i_tx,      // Byte offered by the framer
    input  wire logic       i_slow,    // Stall at random when high
    output logic            o_ready    // Byte taken this edge
);
    logic [7:0] got[$];
    initial o_ready = 1'b1;
    // Ready moves off the sampling edge, prompt or stalling
    always @(negedge i_sys_clk) o_ready <= i_slow ? 1'($urandom_range(1)) : 1'b1;
    always @(posedge i_sys_clk) if (i_tx.valid === 1'b1 && o_ready) got.push_back(i_tx.data);
endmodule // ssf_host_model
`default_nettype wire

// >>> bench/ssf_framer_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module ssf_framer_tb_top
    import ssf_pkg::*;
;
    typedef logic [7:0] ssf_bq_type[$];
    logic             clk, rst_n, req, rdy, busy, en, bbyte, bstart, bend, stopped;
    logic             exec, go, rrst, trip, decel, coast, slow;
    logic [7:0]       sid, bdata, st;
    logic [13:0]      limit;
    logic [10:0]      xdly;
    ssf_char_req_type info;
    ssf_react_type    react;
    ssf_tx_type       tx;
    int               fails, check_count, go_n, exec_n, rr_n;
    logic [7:0]       codes[12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
                                    8'h11, 8'h13, 8'h16};

    ssf_framer #(.SILENT_CYCLES(20), .MS_CYCLES(4), .TICK_CYCLES(4)) dut (
        .i_sys_clk(clk), .i_reset_n(rst_n), .i_station_id(sid), .i_char_req(req), .i_char_info(info),
        .i_tx_ready(rdy), .o_tx(tx), .o_char_busy(busy), .i_comm_enable(en), .i_bin_byte(bbyte),
        .i_bin_data(bdata), .i_bin_frame_start(bstart), .i_bin_frame_end(bend), .i_limit_time(limit),
        .i_extra_delay(xdly), .i_timeout_react(react), .i_motor_stopped(stopped), .o_bin_exec(exec),
        .o_bin_resp_go(go), .o_rx_restart(rrst), .o_link_timeout_trip(trip), .o_decel_stop(decel),
        .o_coast_to_stop(coast));
    ssf_host_model host (.i_sys_clk(clk), .i_tx(tx), .i_slow(slow), .o_ready(rdy));

    // Clock of 40 ns
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Pulse tallies
    always @(posedge clk) begin
        go_n += int'(go === 1'b1);
        exec_n += int'(exec === 1'b1);
        rr_n += int'(rrst === 1'b1);
    end
    // Hex character of a nibble, capitals
    function automatic logic [7:0] hx(input logic [3:0] n);
        return (n < 10) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
    endfunction
    // Expected answer frame
    function automatic ssf_bq_type frame(input logic [7:0] s, input logic [7:0] e);
        ssf_bq_type q;
        logic [7:0] b;
        q = '{8'h30 + s / 10, 8'h30 + s % 10};
        if (e == 8'h00) begin
            q.push_back(8'h06);
        end else begin
            q.push_back(8'h15);
            q.push_back(hx(e[7:4]));
            q.push_back(hx(e[3:0]));
        end
        b = 8'h00;
        foreach (q[i]) b ^= q[i];
        q.push_back(hx(b[7:4]));
        q.push_back(hx(b[3:0]));
        q.push_front(8'h02);
        q.push_back(8'h0d);
        return q;
    endfunction
    // Reflected CRC-16 over a byte list
    function automatic logic [15:0] crc(input ssf_bq_type q);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[i]) begin
            c ^= {8'h00, q[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
    endtask
    task automatic bin_byte(input logic [7:0] b, input logic first);
        @(negedge clk);
        {bbyte, bstart, bdata} = {1'b1, first, b};
        @(negedge clk);
        {bbyte, bstart} = 2'b00;
    endtask
    // One answer request, then frame compare
    task automatic char_test(input logic [7:0] s, input logic [7:0] e, input logic [7:0] to);
        ssf_bq_type x;
        if (to == s) x = frame(s, e);
        host.got.delete();
        @(negedge clk);
        sid = s;
        info = '{to, ssf_err_type'(e)};
        slow = 1'($urandom_range(1));
        // request stands for a received recalc command frame
        req = 1'b1;
        @(negedge clk);
        req = 1'b0;
        for (int n = 0; n < 3000 && host.got.size() < x.size(); n++) @(negedge clk);
        repeat (20) @(negedge clk);
        `CHK(busy, 1'b0)
        `CHK(host.got.size(), x.size())
        foreach (x[i]) `CHK(host.got[i], x[i])
    endtask
    // Binary query with good or broken check field
    task automatic bin_send(input logic [7:0] a, input logic good);
        ssf_bq_type q;
        logic [15:0] c;
        q = '{a, 8'h03, 8'h00, 8'($urandom_range(255))};
        c = crc(q) ^ {15'h0, !good};
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        foreach (q[i]) bin_byte(q[i], i == 0);
        repeat (2) @(negedge clk);
        bend = 1'b1;
        {go_n, exec_n} = '0;
        @(negedge clk);
        bend = 1'b0;
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #(40ns * 60000);
        fails++;
        summarize();
    end
    initial begin
        void'($urandom(32'hfbd004bd));
        {req, bbyte, bstart, bend, stopped, slow, bdata, info} = '0;
        en = 1'b1;
        sid = 8'h01;
        limit = 14'h0;
        xdly = 11'h0;
        react = REACT_IGNORE;
        do_reset();
        foreach (codes[i]) begin
            st = 8'($urandom_range(32, 1));
            char_test(st, codes[i], st);
        end
        char_test(8'h20, 8'h16, 8'h20);
        char_test(st, 8'h00, 8'hff);
        char_test(st, 8'h00, (st == 8'h20) ? 8'h01 : st + 1);
        $display("test char frames done");
        // Own, broadcast, other station, bad check
        for (int k = 0; k < 4; k++) begin
            xdly = 11'($urandom_range(3));
            bin_send((k == 1) ? 8'h00 : (k == 2) ? sid + 1 : sid, k != 3);
            repeat (20 + 4 * xdly - 3) @(negedge clk);
            `CHK(go_n, 0)
            repeat (10) @(negedge clk);
            `CHK(go_n, int'(k == 0))
            `CHK(exec_n, int'(k < 2))
        end
        $display("test binary replies done");
        // Every reaction, then with the link disabled
        for (int r = 0; r < 6; r++) begin
            react = ssf_react_type'(r % 5);
            en = (r < 5);
            limit = 14'($urandom_range(3, 1));
            stopped = 1'($urandom_range(1));
            do_reset();
            rr_n = 0;
            repeat (30) @(negedge clk);
            `CHK(rr_n, 0)
            bin_byte(sid, 1'b1);
            repeat (30) @(negedge clk);
            `CHK(rr_n > 0, r < 5)
            `CHK(trip, r == 0 || (r == 1 && stopped))
            `CHK(decel, r == 1 || r == 4)
            `CHK(coast, r == 3)
            stopped = 1'b1;
            repeat (4) @(negedge clk);
            `CHK(trip, r < 2)
        end
        $display("test timeout reactions done");
        summarize();
    end
endmodule // ssf_framer_tb_top
`default_nettype wire
